// ### design/cbt_core.sv
`timescale 1ns/1ps
`include "cbt_params.svh"
// Functional notes
// - Low status byte shows one active interrupt per object 7..0.
// - Low status register is read only; writes are ignored.
// - Upper enable bits 6..0 permit interrupts of objects 14..8.
// - Upper enable bit n belongs to object n plus 8.
// - Lower enable bits 7..0 permit interrupts of objects 7..0.
// - Both enable registers reset to zero.
// - Time quantum is CAN clock divided by prescaler plus one.
// - Jump width is its field plus one quanta.
// - Resynchronise on the first recessive-to-dominant edge outside the sync segment in each bit, limited by jump width.
// - Propagation segment lasts its field plus one quanta.
// - Phase segments last field plus one quanta, adjusted by resync.
// - Upper status register shows objects 14..8 in bits 6..0.
module cbt_core
   import cbt_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   // Register port
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic [7:0]       sfr_rdata_o,
   // Controller state
   input  wire logic        controller_enable_bit_i,
   input  wire logic [14:0] object_irq_cond_i,
   input  wire logic        can_rx_i,
   // Outputs
   output logic [14:0]      object_irq_req_o,
   output logic             tq_tick_o,
   output logic             sample_point_o,
   output logic             bit_start_o
);
   import cbt_pkg::*;

   typedef struct packed {
      logic [7:0]  bt1;
      logic [7:0]  bt2;
      logic [7:0]  bt3;
      logic [6:0]  ien_high;
      logic [7:0]  ien_low;
      logic [14:0] flag;
      logic        rx_m;
      logic        rx_s;
      logic        rx_prev;
      logic        synced;
      cbt_seg_e    seg;
      logic [3:0]  cnt;
      logic [3:0]  ph1_len;
      logic [3:0]  ph2_len;
      logic        samp;
      logic        bstart;
   } cbt_core_s;
   cbt_core_s s_q;
   cbt_core_s s_d;

   logic       tick;
   logic [3:0] prs_len;
   logic [3:0] ph1_nom;
   logic [3:0] ph2_nom;
   logic [3:0] sjw_len;
   logic [3:0] err;
   logic       edge_seen;

   cbt_tq_div u_div (
      .clk_sys_i  (clk_sys_i),
      .arst_n_i   (arst_n_i),
      .run_i      (controller_enable_bit_i),
      .prescale_i (s_q.bt1[`CBT_BRP_MSB:`CBT_BRP_LSB]),
      .tq_tick_o  (tick)
   );

   // ----------------------------------------
   // Segment lengths
   // ----------------------------------------
   // propagation length
   assign prs_len = {1'b0, s_q.bt2[`CBT_PRS_MSB:`CBT_PRS_LSB]} + 4'h1;
   assign ph1_nom = {1'b0, s_q.bt3[`CBT_PH1_MSB:`CBT_PH1_LSB]} + 4'h1;
   assign ph2_nom = {1'b0, s_q.bt3[`CBT_PH2_MSB:`CBT_PH2_LSB]} + 4'h1;
   assign sjw_len = {2'b00, s_q.bt2[`CBT_SJW_MSB:`CBT_SJW_LSB]} + 4'h1;
   assign edge_seen = s_q.rx_prev && !s_q.rx_s;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      err = 4'h0;
      s_d.samp = 1'b0;
      s_d.bstart = 1'b0;
      s_d.rx_m = can_rx_i;
      s_d.rx_s = s_q.rx_m;
      s_d.flag = object_irq_cond_i;
      if (sfr_wr_i && !controller_enable_bit_i) begin
         unique case (sfr_addr_i)
            `CBT_ADDR_PRESCALER: s_d.bt1 = sfr_wdata_i & `CBT_MASK_BT1;
            `CBT_ADDR_JUMP_PROP: s_d.bt2 = sfr_wdata_i & `CBT_MASK_BT2;
            `CBT_ADDR_PHASE:     s_d.bt3 = sfr_wdata_i & `CBT_MASK_BT3;
            default: ;
         endcase
      end
      if (sfr_wr_i) begin
         if (sfr_addr_i == `CBT_ADDR_IEN_HIGH) begin
            s_d.ien_high = sfr_wdata_i[6:0];
         end
         if (sfr_addr_i == `CBT_ADDR_IEN_LOW) begin
            s_d.ien_low = sfr_wdata_i;
         end
      end
      if (!controller_enable_bit_i) begin
         s_d.seg = CBT_SYNC;
         s_d.cnt = 4'h0;
         s_d.synced = 1'b0;
         s_d.rx_prev = 1'b1;
      end else if (tick) begin
         s_d.rx_prev = s_q.rx_s;
         s_d.cnt = s_q.cnt + 4'h1;
         unique case (s_q.seg)
            CBT_SYNC: begin
               s_d.seg = CBT_PROP;
               s_d.cnt = 4'h0;
               s_d.synced = 1'b0;
               s_d.ph1_len = ph1_nom;
               s_d.ph2_len = ph2_nom;
               s_d.bstart = 1'b1;
            end
            CBT_PROP: begin
               if (edge_seen && !s_q.synced) begin
                  err = (s_q.cnt + 4'h1 > sjw_len) ? sjw_len : s_q.cnt + 4'h1;
                  s_d.ph1_len = s_q.ph1_len + err;
                  s_d.synced = 1'b1;
               end
               if (s_q.cnt + 4'h1 >= prs_len) begin
                  s_d.seg = CBT_PHS1;
                  s_d.cnt = 4'h0;
               end
            end
            CBT_PHS1: begin
               if (edge_seen && !s_q.synced) begin
                  err = ({1'b0, s_q.cnt} + {1'b0, prs_len} + 5'h01 > {1'b0, sjw_len}) ? sjw_len
                                                                                      : s_q.cnt + prs_len + 4'h1;
                  s_d.ph1_len = s_q.ph1_len + err;
                  s_d.synced = 1'b1;
               end
               if (s_q.cnt + 4'h1 >= s_d.ph1_len) begin
                  s_d.seg = CBT_PHS2;
                  s_d.cnt = 4'h0;
                  s_d.samp = 1'b1;
               end
            end
            CBT_PHS2: begin
               if (edge_seen && !s_q.synced) begin
                  err = s_q.ph2_len - s_q.cnt;
                  if (err > sjw_len) begin
                     s_d.ph2_len = s_q.ph2_len - sjw_len;
                     s_d.synced = 1'b1;
                  end else begin
                     s_d.seg = CBT_PROP;
                     s_d.cnt = 4'h0;
                     s_d.synced = 1'b0;
                     s_d.ph1_len = ph1_nom;
                     s_d.ph2_len = ph2_nom;
                     s_d.bstart = 1'b1;
                  end
               end
               if (s_d.seg == CBT_PHS2 && s_q.cnt + 4'h1 >= s_d.ph2_len) begin
                  s_d.seg = CBT_SYNC;
                  s_d.cnt = 4'h0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Read mux and outputs
   // ----------------------------------------
   always_comb begin
      unique case (sfr_addr_i)
         `CBT_ADDR_PRESCALER: sfr_rdata_o = s_q.bt1;
         `CBT_ADDR_JUMP_PROP: sfr_rdata_o = s_q.bt2;
         `CBT_ADDR_PHASE:     sfr_rdata_o = s_q.bt3;
         `CBT_ADDR_STAT_HIGH: sfr_rdata_o = {1'b0, s_q.flag[14:8]};
         `CBT_ADDR_STAT_LOW:  sfr_rdata_o = s_q.flag[7:0];
         `CBT_ADDR_IEN_HIGH:  sfr_rdata_o = {1'b0, s_q.ien_high};
         `CBT_ADDR_IEN_LOW:   sfr_rdata_o = s_q.ien_low;
         default:             sfr_rdata_o = `CBT_RST_BYTE;
      endcase
   end

   assign object_irq_req_o = s_q.flag & {s_q.ien_high, s_q.ien_low};
   assign tq_tick_o = tick;
   assign sample_point_o = s_q.samp;
   assign bit_start_o = s_q.bstart;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '{bt1: 8'h00, bt2: 8'h00, bt3: 8'h00, ien_high: 7'h00, ien_low: 8'h00,
                  flag: 15'h0000, rx_m: 1'b1, rx_s: 1'b1, rx_prev: 1'b1, synced: 1'b0,
                  seg: CBT_SYNC, cnt: 4'h0, ph1_len: 4'h1, ph2_len: 4'h1, samp: 1'b0, bstart: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ### design/cbt_params.svh
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CBT_ADDR_PRESCALER 8'hB4
`define CBT_ADDR_JUMP_PROP 8'hB5
`define CBT_ADDR_PHASE     8'hB6
`define CBT_ADDR_STAT_HIGH 8'hBA
`define CBT_ADDR_STAT_LOW  8'hBB
`define CBT_ADDR_IEN_HIGH  8'hC2
`define CBT_ADDR_IEN_LOW   8'hC3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CBT_BRP_MSB 6
`define CBT_BRP_LSB 1
`define CBT_SJW_MSB 6
`define CBT_SJW_LSB 5
`define CBT_PRS_MSB 3
`define CBT_PRS_LSB 1
`define CBT_PH2_MSB 6
`define CBT_PH2_LSB 4
`define CBT_PH1_MSB 3
`define CBT_PH1_LSB 1
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CBT_RST_BYTE    8'h00
`define CBT_MASK_HIGH7  8'h7F
`define CBT_MASK_BT1    8'h7E
`define CBT_MASK_BT2    8'h6E
`define CBT_MASK_BT3    8'h7F
`define CBT_NUM_OBJ     15
`endif

// ### design/cbt_pkg.sv
package cbt_pkg;
   typedef logic [7:0] cbt_byte_t;
   typedef enum logic [3:0] {
      CBT_SYNC  = 4'h1,
      CBT_PROP  = 4'h2,
      CBT_PHS1  = 4'h4,
      CBT_PHS2  = 4'h8
   } cbt_seg_e;
endpackage

// ### design/cbt_tq_div.sv
`timescale 1ns/1ps
`include "cbt_params.svh"
module cbt_tq_div
   import cbt_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [5:0] prescale_i,
   // Quantum tick
   output logic            tq_tick_o
);
   typedef struct packed {
      logic [5:0] cnt;
   } cbt_div_s;
   cbt_div_s s_q;
   cbt_div_s s_d;

   always_comb begin
      s_d = s_q;
      if (!run_i || s_q.cnt >= prescale_i) begin
         s_d.cnt = 6'h00;
      end else begin
         s_d.cnt = s_q.cnt + 6'h01;
      end
   end

   assign tq_tick_o = run_i && (s_q.cnt >= prescale_i);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ### sim/cbt_core_properties.sv
`timescale 1ns/1ps
module cbt_core_properties (
   input wire logic        clk_sys_i,
   input wire logic        arst_n_i,
   input wire logic [7:0]  sfr_addr_i,
   input wire logic        sfr_wr_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic [7:0]  sfr_rdata_o,
   input wire logic        controller_enable_bit_i,
   input wire logic [14:0] object_irq_cond_i,
   input wire logic [14:0] object_irq_req_o,
   input wire logic        tq_tick_o,
   input wire logic        sample_point_o,
   input wire logic        bit_start_o
);
   logic [5:0] brp_q;
   logic [6:0] gap_q;
   logic [14:0] ien_q;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         brp_q <= 6'h00;
         gap_q <= 7'h00;
         ien_q <= 15'h0000;
      end else begin
         if (sfr_wr_i && sfr_addr_i == 8'hC2)
            ien_q[14:8] <= sfr_wdata_i[6:0];
         if (sfr_wr_i && sfr_addr_i == 8'hC3)
            ien_q[7:0] <= sfr_wdata_i;
         if (sfr_wr_i && !controller_enable_bit_i && sfr_addr_i == 8'hB4)
            brp_q <= sfr_wdata_i[6:1];
         gap_q <= !controller_enable_bit_i ? 7'h00 : tq_tick_o ? 7'h01 : gap_q + {6'h00, gap_q != 7'h00};
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   a_tick_period: assert property (tq_tick_o && gap_q != 7'h00 |-> gap_q == {1'b0, brp_q} + 7'h01)
      else $error("quantum tick spacing wrong");
   a_tick_idle: assert property (!controller_enable_bit_i && !$past(controller_enable_bit_i) |-> !tq_tick_o)
      else $error("quantum tick while disabled");
   a_stat_low: assert property (sfr_addr_i == 8'hBB && $past(arst_n_i) |-> sfr_rdata_o == $past(object_irq_cond_i[7:0]))
      else $error("low status byte wrong");
   a_req_gate: assert property (object_irq_req_o == ($past(object_irq_cond_i) & ien_q))
      else $error("request without status");
   a_ien_low: assert property (sfr_wr_i && sfr_addr_i == 8'hC3 ##1 sfr_addr_i == 8'hC3 |-> sfr_rdata_o == $past(sfr_wdata_i))
      else $error("low enable write lost");
   a_ien_high: assert property (sfr_wr_i && sfr_addr_i == 8'hC2 ##1 sfr_addr_i == 8'hC2 |-> sfr_rdata_o == ($past(sfr_wdata_i) & 8'h7F))
      else $error("high enable write wrong");
   a_bt_locked: assert property (controller_enable_bit_i && sfr_addr_i == 8'hB4 ##1 sfr_addr_i == 8'hB4 |-> $stable(sfr_rdata_o))
      else $error("timing changed while enabled");
   a_bit_order: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i || !controller_enable_bit_i)
      bit_start_o |-> ##[1:1000] sample_point_o)
      else $error("no sample point after bit start");
   cover property (sample_point_o);
   cover property (object_irq_req_o != 15'h0000);
   cover property (sfr_wr_i && sfr_addr_i == 8'hBB);
endmodule
bind cbt_core cbt_core_properties u_props (
   .clk_sys_i               (clk_sys_i),
   .arst_n_i                (arst_n_i),
   .sfr_addr_i              (sfr_addr_i),
   .sfr_wr_i                (sfr_wr_i),
   .sfr_wdata_i             (sfr_wdata_i),
   .sfr_rdata_o             (sfr_rdata_o),
   .controller_enable_bit_i (controller_enable_bit_i),
   .object_irq_cond_i       (object_irq_cond_i),
   .object_irq_req_o        (object_irq_req_o),
   .tq_tick_o               (tq_tick_o),
   .sample_point_o          (sample_point_o),
   .bit_start_o             (bit_start_o)
);

// ### sim/cbt_node_model.sv
`timescale 1ns/1ps
module cbt_node_model #(parameter int BIT_CLKS = 20) (
   input  wire logic clk_sys_i,
   input  wire logic node_en_i,
   output logic      can_rx_o
);
   int cnt = 0;
   // Recessive when idle; alternating bits on a slightly slower bit clock.
   always @(posedge clk_sys_i) begin
      cnt <= (!node_en_i || cnt == BIT_CLKS - 1) ? 0 : cnt + 1;
      if (!node_en_i)
         can_rx_o <= 1'b1;
      else if (cnt == 0)
         can_rx_o <= ~can_rx_o;
   end
endmodule

// ### sim/cbt_core_tb.sv
`timescale 1ns/1ps
module cbt_core_tb;
   localparam logic [7:0] AL [8] = '{8'hB4, 8'hB5, 8'hB6, 8'hBA, 8'hBB, 8'hC2, 8'hC3, 8'hA0};
   logic        clk_sys_i = 1'b0, arst_n_i = 1'b0, sfr_wr_i = 1'b0;
   logic        controller_enable_bit_i = 1'b0, node_en = 1'b0, moved;
   logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic [14:0] object_irq_cond_i = 15'h0000, object_irq_req_o;
   logic        can_rx_i, tq_tick_o, sample_point_o, bit_start_o;
   int          n_fail = 0, checks = 0, cyc = 0, n;
   always #2.5 clk_sys_i = ~clk_sys_i;
   cbt_core u_dut (
      .clk_sys_i               (clk_sys_i),
      .arst_n_i                (arst_n_i),
      .sfr_addr_i              (sfr_addr_i),
      .sfr_wr_i                (sfr_wr_i),
      .sfr_wdata_i             (sfr_wdata_i),
      .sfr_rdata_o             (sfr_rdata_o),
      .controller_enable_bit_i (controller_enable_bit_i),
      .object_irq_cond_i       (object_irq_cond_i),
      .can_rx_i                (can_rx_i),
      .object_irq_req_o        (object_irq_req_o),
      .tq_tick_o               (tq_tick_o),
      .sample_point_o          (sample_point_o),
      .bit_start_o             (bit_start_o)
   );
   cbt_node_model u_node (.clk_sys_i(clk_sys_i), .node_en_i(node_en), .can_rx_o(can_rx_i));
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) chk(15'h0000, 15'h0001);
      if (cyc == 20000) results();
   end
   task results();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [14:0] s, input logic [14:0] e);
      checks++;
      if (s !== e) $display("Error %0t: got %h want %h", $time, s, e);
      if (s !== e) n_fail++;
   endtask
   task wrt(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge clk_sys_i);
      sfr_wr_i = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_sys_i);
      sfr_addr_i = a;
      #1 chk(15'(sfr_rdata_o), 15'(e));
   endtask
   task meas(input int w);
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (!(w == 0 ? tq_tick_o : (w == 1 ? sample_point_o : bit_start_o)) && n < 999);
   endtask
   task t_regs();
      foreach (AL[i]) rd(AL[i], 8'h00);
      wrt(8'hC2, 8'h7F);
      rd(8'hC2, 8'h7F);
      wrt(8'hB5, 8'h6E);
      rd(8'hB5, 8'h6E);
   endtask
   task t_irq();
      wrt(8'hC2, 8'h0C);
      wrt(8'hC3, 8'h0C);
      object_irq_cond_i = 15'h7FFF;
      rd(8'hBB, 8'hFF);
      rd(8'hBA, 8'h7F);
      chk(object_irq_req_o, 15'h0C0C);
      wrt(8'hBB, 8'h00);
      rd(8'hBB, 8'hFF);
      @(negedge clk_sys_i);
      object_irq_cond_i = 15'h0000;
      rd(8'hBB, 8'h00);
      chk(object_irq_req_o, 15'h0000);
   endtask
   task t_timing();
      wrt(8'hB4, 8'h02);
      wrt(8'hB5, 8'h02);
      wrt(8'hB6, 8'h16);
      controller_enable_bit_i = 1'b1;
      wrt(8'hB4, 8'h7E);
      rd(8'hB4, 8'h02);
      meas(0);
      meas(0);
      chk(15'(n), 15'h0002);
      meas(2);
      meas(1);
      chk(15'(n), 15'h000C);
      meas(2);
      chk(15'(n), 15'h0006);
   endtask
   task t_resync();
      moved = 1'b0;
      node_en = 1'b1;
      meas(2);
      repeat (8) begin
         meas(2);
         chk(15'(n >= 16 && n <= 20), 15'h0001);
         moved |= (n != 18);
      end
      chk(15'(moved), 15'h0001);
   endtask
   initial begin
      repeat (10) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      t_regs();
      t_irq();
      t_timing();
      t_resync();
      results();
   end
endmodule
